// File: rtl/rotate_pkg.sv
// constants for the rotate-right-no-carry datapath
// assumes a single clock and a synchronous active-high reset
package rotate_pkg;
    localparam int DATA_W = 8;
    localparam int OPC_W = 16;
    localparam int ADDR_W = 12;
    localparam int BANK_W = 4;
    localparam logic [5:0] OPC_ROTATE = 6'h10;
    localparam int OPC_HI = 15;
    localparam int OPC_LO = 10;
    localparam int DEST_BIT = 9;
    localparam int WIN_BIT = 8;
    localparam logic [7:0] INDEX_LIMIT = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [15:0] NOP_WORD = 16'h0000;
    typedef enum logic [1:0] {
        PH_DECODE = 2'b00,
        PH_READ = 2'b01,
        PH_PROCESS = 2'b11,
        PH_WRITE = 2'b10
    } phase_t;
endpackage

// File: rtl/rotate_right_no_carry_op.sv
// Overview of operation
// RL1 - rotate source right one bit, bit0 to bit7, set negative and zero flags
// RL2 - destination bit clear: result to accumulator, source unchanged
// RL3 - destination bit set: result written back to source register
// RL4 - window bit clear: operand in access bank, bank pointer ignored
// RL5 - window bit set: address is bank pointer joined with register field
// RL6 - window clear, extended set on, field at most 95: indexed literal offset
// RL7 - opcode top six bits 010000, then d, a, field; one four-phase cycle
//
// single-instruction core slice: fetch word in, data memory port out
// assumes memory read data stands while mem_read_strobe is high
// each instruction phase lasts one clock; done closes the instruction
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module rotate_right_no_carry_op
    import rotate_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [OPC_W-1:0] instr_word,
    input wire logic instr_valid,
    input wire logic [BANK_W-1:0] bank_pointer,
    input wire logic extended_enable,
    input wire logic [ADDR_W-1:0] index_base,
    input wire logic [DATA_W-1:0] mem_read_data,
    output logic [ADDR_W-1:0] mem_addr,
    output logic mem_read_strobe,
    output logic mem_write_strobe,
    output logic [DATA_W-1:0] mem_write_data,
    output logic [DATA_W-1:0] accumulator,
    output logic msb_set_flag,
    output logic result_null_flag,
    output logic busy,
    output logic done,
    output logic illegal_opcode
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    phase_t phase_reg, phase_next;
    logic [OPC_W-1:0] word_reg, word_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [DATA_W-1:0] data_reg, data_next;
    logic [DATA_W-1:0] acc_reg, acc_next;
    logic neg_reg, neg_next, zero_reg, zero_next;
    logic rd_reg, rd_next, wr_reg, wr_next;
    logic busy_reg, busy_next, done_reg, done_next, bad_reg, bad_next;
    logic [DATA_W-1:0] wdata_reg, wdata_next;

    logic [DATA_W-1:0] rot_result;
    logic rot_msb, rot_null;
    logic [7:0] field;
    logic [ADDR_W-1:0] eff_addr;

    rotate_unit #(.WIDTH(DATA_W)) u_rotate (
        .operand(data_reg),
        .result(rot_result),
        .msb_set(rot_msb),
        .is_null(rot_null)
    );

    // ----------------------------------------------------------------
    // operand address
    // ----------------------------------------------------------------
    always_comb begin
        field = word_reg[7:0];
        if (word_reg[WIN_BIT]) begin
            eff_addr = {bank_pointer, field}; // RL5
        end else if (extended_enable && field <= INDEX_LIMIT) begin
            eff_addr = index_base + {4'h0, field}; // RL6
        end else if (field < ACCESS_SPLIT) begin
            eff_addr = {4'h0, field}; // RL4
        end else begin
            eff_addr = {ACCESS_HI_BANK, field}; // RL4
        end
    end

    // ----------------------------------------------------------------
    // instruction decode
    // ----------------------------------------------------------------
    logic in_decode;
    logic in_read;
    logic in_process;
    logic in_write;
    logic opcode_match;
    logic take_word;
    logic refuse_word;
    logic dest_to_file;

    always_comb begin
        in_decode = (phase_reg == PH_DECODE);
        in_read = (phase_reg == PH_READ);
        in_process = (phase_reg == PH_PROCESS);
        in_write = (phase_reg == PH_WRITE);
        opcode_match = (instr_word[OPC_HI:OPC_LO] == OPC_ROTATE); // RL7
        take_word = in_decode && instr_valid && opcode_match; // RL7
        refuse_word = in_decode && instr_valid && !opcode_match;
        dest_to_file = word_reg[DEST_BIT]; // RL2 RL3
    end

    // ----------------------------------------------------------------
    // phase sequencer: decode, read, process, write
    // ----------------------------------------------------------------
    always_comb begin
        phase_next = phase_reg;
        unique case (phase_reg)
            PH_DECODE: begin
                if (take_word) begin
                    phase_next = PH_READ; // RL7
                end
            end
            PH_READ: begin
                phase_next = PH_PROCESS;
            end
            PH_PROCESS: begin
                phase_next = PH_WRITE;
            end
            PH_WRITE: begin
                phase_next = PH_DECODE; // RL7
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            phase_reg <= PH_DECODE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // ----------------------------------------------------------------
    // instruction hold and busy
    // ----------------------------------------------------------------
    always_comb begin
        word_next = word_reg;
        busy_next = busy_reg;
        if (take_word) begin
            word_next = instr_word; // RL7
            busy_next = 1'b1;
        end else if (in_write) begin
            busy_next = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            word_reg <= NOP_WORD;
            busy_reg <= 1'b0;
        end else begin
            word_reg <= word_next;
            busy_reg <= busy_next;
        end
    end

    // ----------------------------------------------------------------
    // illegal opcode pulse
    // ----------------------------------------------------------------
    always_comb begin
        bad_next = refuse_word; // RL7
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            bad_reg <= 1'b0;
        end else begin
            bad_reg <= bad_next;
        end
    end

    // ----------------------------------------------------------------
    // operand read port
    // ----------------------------------------------------------------
    always_comb begin
        addr_next = addr_reg;
        rd_next = 1'b0;
        if (in_read) begin
            addr_next = eff_addr; // RL4 RL5 RL6
            rd_next = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            addr_reg <= '0;
            rd_reg <= 1'b0;
        end else begin
            addr_reg <= addr_next;
            rd_reg <= rd_next;
        end
    end

    // ----------------------------------------------------------------
    // operand capture
    // ----------------------------------------------------------------
    always_comb begin
        data_next = data_reg;
        if (in_process) begin
            data_next = mem_read_data;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            data_reg <= ZERO_BYTE;
        end else begin
            data_reg <= data_next;
        end
    end

    // ----------------------------------------------------------------
    // write back to the source register
    // ----------------------------------------------------------------
    always_comb begin
        wr_next = 1'b0;
        wdata_next = wdata_reg;
        if (in_write && dest_to_file) begin
            wr_next = 1'b1; // RL3
            wdata_next = rot_result; // RL3
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            wr_reg <= 1'b0;
            wdata_reg <= ZERO_BYTE;
        end else begin
            wr_reg <= wr_next;
            wdata_reg <= wdata_next;
        end
    end

    // ----------------------------------------------------------------
    // accumulator load
    // ----------------------------------------------------------------
    always_comb begin
        acc_next = acc_reg;
        if (in_write && !dest_to_file) begin
            acc_next = rot_result; // RL2
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            acc_reg <= ZERO_BYTE;
        end else begin
            acc_reg <= acc_next;
        end
    end

    // ----------------------------------------------------------------
    // negative and zero flags
    // ----------------------------------------------------------------
    always_comb begin
        neg_next = neg_reg;
        zero_next = zero_reg;
        if (in_write) begin
            neg_next = rot_msb; // RL1
            zero_next = rot_null; // RL1
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            neg_reg <= 1'b0;
            zero_reg <= 1'b0;
        end else begin
            neg_reg <= neg_next;
            zero_reg <= zero_next;
        end
    end

    // ----------------------------------------------------------------
    // end of instruction pulse
    // ----------------------------------------------------------------
    always_comb begin
        done_next = in_write; // RL7
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= done_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always_comb begin
        mem_addr = addr_reg;
        mem_read_strobe = rd_reg;
        mem_write_strobe = wr_reg;
        mem_write_data = wdata_reg;
        accumulator = acc_reg;
        msb_set_flag = neg_reg;
        result_null_flag = zero_reg;
        busy = busy_reg;
        done = done_reg;
        illegal_opcode = bad_reg;
    end
endmodule
`default_nettype wire

// File: rtl/rotate_unit.sv
// combinational rotate right by one, no carry, with flag outputs
// assumes operand is valid for the whole write phase
`timescale 1ns/100ps
`default_nettype none
module rotate_unit
    import rotate_pkg::*;
#(
    parameter int WIDTH = DATA_W
) (
    input wire logic [WIDTH-1:0] operand,
    output logic [WIDTH-1:0] result,
    output logic msb_set,
    output logic is_null
);
    always_comb begin
        result = {operand[0], operand[WIDTH-1:1]}; // RL1
        msb_set = result[WIDTH-1]; // RL1
        is_null = (result == '0); // RL1
    end
endmodule
`default_nettype wire

// File: test/rotate_asserts.sv
// port checker for the rotate slice
// assumes a bind onto the slice top
`timescale 1ns/100ps
`default_nettype none
module rotate_asserts
    import rotate_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [OPC_W-1:0] instr_word,
    input wire logic instr_valid,
    input wire logic [BANK_W-1:0] bank_pointer,
    input wire logic extended_enable,
    input wire logic [ADDR_W-1:0] index_base,
    input wire logic [DATA_W-1:0] mem_read_data,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic mem_read_strobe,
    input wire logic mem_write_strobe,
    input wire logic [DATA_W-1:0] mem_write_data,
    input wire logic [DATA_W-1:0] accumulator,
    input wire logic msb_set_flag,
    input wire logic result_null_flag,
    input wire logic busy,
    input wire logic done,
    input wire logic illegal_opcode
);
    logic go, dr;
    logic [7:0] f, rd, rr;
    logic [11:0] ea;
    assign go = instr_valid && !busy && instr_word[OPC_HI:OPC_LO] == OPC_ROTATE;
    assign f = instr_word[7:0];
    assign rr = {rd[0], rd[7:1]};
    always_ff @(posedge clock) begin
        if (mem_read_strobe) rd <= mem_read_data;
        if (go) dr <= instr_word[DEST_BIT];
        if (go) ea <= instr_word[WIN_BIT] ? {bank_pointer, f} :
            extended_enable && f <= INDEX_LIMIT ? index_base + {4'h0, f} :
            {f < ACCESS_SPLIT ? 4'h0 : ACCESS_HI_BANK, f};
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    a_read_slot: assert property (go |-> ##[2:3] mem_read_strobe)
        else $error("read slot");
    a_done_gap: assert property (mem_read_strobe |-> ##2 done)
        else $error("done gap");
    a_busy_span: assert property (go |=> busy ##1 busy ##1 busy ##1 !busy)
        else $error("busy span");
    a_bad_word: assert property (instr_valid && !busy && !go |=> illegal_opcode)
        else $error("bad word");
    a_flag_value: assert property (done |-> msb_set_flag == rr[7] && result_null_flag == !rr)
        else $error("flags");
    a_write_back: assert property (done |-> mem_write_strobe == dr)
        else $error("write back");
    a_write_data: assert property (mem_write_strobe |-> mem_write_data == rr)
        else $error("write data");
    a_acc_load: assert property (done && !dr |-> accumulator == rr)
        else $error("accumulator");
    a_addr_form: assert property (mem_read_strobe |-> mem_addr == ea)
        else $error("address");
endmodule
bind rotate_right_no_carry_op rotate_asserts u_asserts (.*);
`default_nettype wire

// File: test/tb_rotate_right_no_carry_op.sv
// bench for the rotate slice: random words, queued results
// assumes the checker binds itself
`timescale 1ns/100ps
`default_nettype none
module tb_rotate_right_no_carry_op
    import rotate_pkg::*;
;
    logic clock = '0, reset = '1, instr_valid = '0, extended_enable = '0;
    logic [15:0] instr_word = '0, w;
    logic [3:0] bank_pointer = '0;
    logic [11:0] index_base = '0, mem_addr, la;
    logic [7:0] mem_read_data = '0, accumulator, mem_write_data, am = '0, v, rt;
    logic mem_read_strobe, mem_write_strobe, msb_set_flag, result_null_flag;
    logic busy, done, illegal_opcode;
    logic [30:0] q[$], got;
    logic [31:0] s = 32'h0000F1A2;
    int n_mismatch = 0, comparisons = 0, cyc = 0, k, j;
    rotate_right_no_carry_op uut (.*);
    assign got = {la, accumulator, msb_set_flag, result_null_flag, mem_write_strobe,
        mem_write_strobe ? mem_write_data : 8'h00};
    always #20 clock = ~clock;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    function automatic logic [11:0] ea(input logic a, x, input logic [7:0] f);
        if (a) return {bank_pointer, f};
        if (x && f <= 8'h5F) return index_base + {4'h0, f};
        return {f < 8'h60 ? 4'h0 : 4'hF, f};
    endfunction
    task automatic check(input logic [30:0] g, e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: %h vs %h", $time, g, e);
        end
    endtask
    task automatic print_verdict();
        $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (mem_read_strobe) la <= mem_addr;
        if (done) check(got, q.pop_front());
        if (cyc == 2000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge clock);
        reset <= 1'h0;
        @(posedge clock);
        for (k = 0; k < 60; k++) begin
            s = xs(s);
            w = {k % 7 == 6 ? s[15:10] | 6'h01 : OPC_ROTATE, s[9], k > 1 && s[8], s[7:0]};
            if (k < 2) w[7:0] = 8'h5F + k[7:0];
            v = k % 5 ? s[31:24] : 8'h00;
            rt = {v[0], v[7:1]};
            instr_word <= w;
            instr_valid <= 1'h1;
            bank_pointer <= s[14:11];
            extended_enable <= k < 2 || s[10];
            index_base <= s[26:15];
            mem_read_data <= v;
            @(posedge clock);
            instr_valid <= 1'h0;
            if (w[15:10] != OPC_ROTATE) begin
                @(posedge clock);
                check({30'h0, illegal_opcode}, 31'h1);
            end else begin
                am = w[9] ? am : rt;
                q.push_back({ea(w[8], extended_enable, w[7:0]), am, rt[7], rt == 8'h00,
                    w[9], w[9] ? rt : 8'h00});
                for (j = 0; j < 8 && done !== 1'b1; j++) @(posedge clock);
                check({30'h0, done}, 31'h1);
            end
        end
        print_verdict();
    end
endmodule
`default_nettype wire
